// ---- src/hip_port.sv ----
/*
 * Strap mode select, async parallel port with open-drain handshake, AXI4-Lite control.
 * Assumes host pins are asynchronous to clk.
 */
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/100ps

// Notes on behaviour
// - mode straps always read, choose host interface
// - link mode: address straps give source address
// - serial modes: divider M, N from data straps
// - serial modes: strap divider overrides register divider write
// - strap mode applies at reset release
// - straps 00 Intel, 01 Motorola parallel port
// - handshake marks each completed access
// - open drain, low only with chip select
// - ready enable low keeps handshake released
// - Intel read: ready after data, hold, release
// - Intel write: ready, release after store
// - ten-bit register address decode
// - 8 or 16 bit data bus
// - byte and word access via A0, byte enable
// - switching latch strobe latches muxed address
// - Intel 16-bit lane table
// - Motorola 16-bit lane table
// - latch strobe toggling in Intel mode picks muxed bus
// - straps 11 select serial control link
module hip_port #(
    parameter int ADDR_W = hip_pkg::HOST_ADDR_W
) (
    input wire logic clk,
    input wire logic reset,
    input hip_pkg::hip_host_in_s host_in,
    input hip_pkg::hip_strap_s straps,
    output hip_pkg::hip_host_out_s host_out,
    output hip_pkg::hip_mode_e active_mode,
    output logic [hip_pkg::SRC_ADDR_W-1:0] link_source_addr,
    output logic [hip_pkg::DIV_M_W-1:0] pll_div_m,
    output logic [hip_pkg::DIV_N_W-1:0] pll_div_n,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import hip_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RD_SETUP,
        ST_RD_WAIT,
        ST_HOLD,
        ST_WR_WAIT,
        ST_WR_STORE
    } hip_state_e;

    // ========================================================
    // synchronisers
    hip_host_in_s pin_s;
    hip_strap_s strap_s;

    // no reset: straps must reach the capture while reset is held
    hip_sync #(.WIDTH($bits(hip_host_in_s)), .RESET_VALUE(HOST_IN_IDLE)) u_sync_host (
        .clk(clk),
        .reset(1'b0),
        .d(host_in),
        .q(pin_s)
    );

    hip_sync #(.WIDTH($bits(hip_strap_s)), .RESET_VALUE('0)) u_sync_strap (
        .clk(clk),
        .reset(1'b0),
        .d(straps),
        .q(strap_s)
    );

    // ========================================================
    // strap capture: follows the pins during reset, frozen at release
    hip_mode_e mode_r;
    logic [SRC_ADDR_W-1:0] src_strap_r;
    logic [DIV_M_W-1:0] m_strap_r;
    logic [DIV_N_W-1:0] n_strap_r;
    logic serial_mode;
    logic intel_mode;

    always_ff @(posedge clk) begin
        if (reset) begin
            mode_r <= hip_mode_e'(strap_s.interface_select_straps);
            src_strap_r <= pin_s.addr[SRC_ADDR_W-1:0];
            m_strap_r <= pin_s.data[STRAP_M_LSB +: DIV_M_W];
            n_strap_r <= pin_s.data[STRAP_N_LSB +: DIV_N_W];
        end
    end

    assign serial_mode = (mode_r == HIP_MODE_SPI) || (mode_r == HIP_MODE_LINK);
    assign intel_mode = (mode_r == HIP_MODE_INTEL);

    // ========================================================
    // software control
    logic [1:0] ctrl_r;
    logic mux_bus_r;
    logic ale_prev_r;

    // latch strobe toggling in Intel mode means a muxed bus
    always_ff @(posedge clk) begin
        if (reset) begin
            ale_prev_r <= 1'b0;
            mux_bus_r <= 1'b0;
        end else begin
            ale_prev_r <= pin_s.ale;
            if (intel_mode && (pin_s.ale != ale_prev_r)) begin
                mux_bus_r <= 1'b1;
            end
        end
    end

    // address latched on the falling latch strobe
    logic [ADDR_W-1:0] mux_addr_r;
    logic [ADDR_W-1:0] cur_addr;

    always_ff @(posedge clk) begin
        if (reset) begin
            mux_addr_r <= '0;
        end else if (pin_s.ale) begin
            mux_addr_r <= pin_s.data[ADDR_W-1:0];
        end
    end

    assign cur_addr = mux_bus_r ? mux_addr_r : pin_s.addr[ADDR_W-1:0];

    // ========================================================
    // lane decode
    function automatic hip_lanes_s decode_lanes(input logic bus16, input logic byte_ok,
            input logic intel, input logic sel_n, input logic a0);
        hip_lanes_s l;
        l = '0;
        if (!bus16) begin
            l.even_en = !a0;
            l.odd_en = a0;
        end else begin
            l.even_en = !a0 && (byte_ok || !sel_n);
            l.odd_en = !sel_n && (byte_ok || !a0);
            l.even_hi = !intel;
            l.odd_hi = intel;
        end
        return l;
    endfunction

    // ========================================================
    // host access sequencer
    localparam int NBYTES = 2 ** ADDR_W;
    logic [7:0] mem [NBYTES];
    hip_state_e state_r;
    hip_lanes_s lanes_r;
    logic [ADDR_W-1:0] even_addr_r;
    logic [HOST_DATA_W-1:0] wdata_r;
    logic [HOST_DATA_W-1:0] rdata_r;
    logic [HOLD_CNT_W-1:0] hold_cnt_r;
    logic ack_r;
    logic drive_r;
    logic strobe;
    logic is_read;
    logic [ADDR_W-1:0] odd_addr;

    assign strobe = intel_mode ? (!pin_s.rd_ds_n || !pin_s.wr_rw_n) : !pin_s.rd_ds_n;
    assign is_read = intel_mode ? !pin_s.rd_ds_n : pin_s.wr_rw_n;
    assign odd_addr = even_addr_r | ADDR_W'(1);

    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= ST_IDLE;
            ack_r <= 1'b0;
            drive_r <= 1'b0;
            lanes_r <= '0;
            even_addr_r <= '0;
            hold_cnt_r <= '0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (!serial_mode && !pin_s.cs_n && strobe) begin
                        lanes_r <= decode_lanes(ctrl_r[CTRL_BUS16_BIT], ctrl_r[CTRL_BYTE_EN_BIT],
                            intel_mode, pin_s.byte_sel_n, cur_addr[0]);
                        even_addr_r <= {cur_addr[ADDR_W-1:1], 1'b0};
                        if (is_read) begin
                            state_r <= ST_RD_SETUP;
                            drive_r <= 1'b1;
                        end else begin
                            state_r <= ST_WR_WAIT;
                            ack_r <= 1'b1;
                        end
                    end
                end
                ST_RD_SETUP: begin
                    state_r <= ST_RD_WAIT;
                end
                ST_RD_WAIT: begin
                    ack_r <= 1'b1;
                    if (!strobe) begin
                        hold_cnt_r <= HOLD_CNT_W'(READY_HOLD_CYC);
                        state_r <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (hold_cnt_r <= HOLD_CNT_W'(1)) begin
                        ack_r <= 1'b0;
                        drive_r <= 1'b0;
                        state_r <= ST_IDLE;
                    end else begin
                        hold_cnt_r <= hold_cnt_r - HOLD_CNT_W'(1);
                    end
                end
                ST_WR_WAIT: begin
                    if (!strobe) begin
                        state_r <= ST_WR_STORE;
                    end
                end
                ST_WR_STORE: begin
                    ack_r <= 1'b0;
                    state_r <= ST_IDLE;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // last data seen with the strobe low
    always_ff @(posedge clk) begin
        if (reset) begin
            wdata_r <= '0;
        end else if (state_r == ST_WR_WAIT && strobe) begin
            wdata_r <= pin_s.data;
        end
    end

    // no reset on the array: read before write gives X
    always_ff @(posedge clk) begin
        if (state_r == ST_WR_STORE) begin
            if (lanes_r.even_en) begin
                mem[even_addr_r] <= lanes_r.even_hi ? wdata_r[15:8] : wdata_r[7:0];
            end
            if (lanes_r.odd_en) begin
                mem[odd_addr] <= lanes_r.odd_hi ? wdata_r[15:8] : wdata_r[7:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_r <= '0;
        end else if (state_r == ST_RD_SETUP) begin
            rdata_r <= '0;
            if (lanes_r.even_en && lanes_r.even_hi) rdata_r[15:8] <= mem[even_addr_r];
            if (lanes_r.even_en && !lanes_r.even_hi) rdata_r[7:0] <= mem[even_addr_r];
            if (lanes_r.odd_en && lanes_r.odd_hi) rdata_r[15:8] <= mem[odd_addr];
            if (lanes_r.odd_en && !lanes_r.odd_hi) rdata_r[7:0] <= mem[odd_addr];
        end
    end

    // ========================================================
    // divider: registers in parallel modes, straps in serial
    logic [DIV_M_W-1:0] div_m_r;
    logic [DIV_N_W-1:0] div_n_r;

    always_ff @(posedge clk) begin
        if (reset) begin
            div_m_r <= DIV_M_RESET;
            div_n_r <= DIV_N_RESET;
        end else if (state_r == ST_WR_STORE && lanes_r.even_en) begin
            if (even_addr_r == HOST_DIV_M_ADDR) begin
                div_m_r <= DIV_M_W'(lanes_r.even_hi ? wdata_r[15:8] : wdata_r[7:0]);
            end
            if (even_addr_r == HOST_DIV_N_ADDR) begin
                div_n_r <= DIV_N_W'(lanes_r.even_hi ? wdata_r[15:8] : wdata_r[7:0]);
            end
        end
    end

    // ========================================================
    // registered outputs
    always_ff @(posedge clk) begin
        if (reset) begin
            host_out <= '0;
            active_mode <= HIP_MODE_INTEL;
            link_source_addr <= '0;
            pll_div_m <= DIV_M_RESET;
            pll_div_n <= DIV_N_RESET;
        end else begin
            host_out.data_out <= rdata_r;
            host_out.data_oe <= drive_r && (state_r != ST_RD_SETUP) && !pin_s.cs_n;
            host_out.handshake_out <= 1'b0;
            host_out.handshake_oe <= ack_r && !pin_s.cs_n && strap_s.ready_enable;
            active_mode <= mode_r;
            link_source_addr <= (mode_r == HIP_MODE_LINK) ? src_strap_r : '0;
            pll_div_m <= serial_mode ? m_strap_r : div_m_r;
            pll_div_n <= serial_mode ? n_strap_r : div_n_r;
        end
    end

    // ========================================================
    // AXI4-Lite slave
    logic aw_got_r;
    logic w_got_r;
    logic [11:0] awaddr_r;
    logic [31:0] wdata_axi_r;
    logic [31:0] rd_word;
    logic rd_ok;

    always_ff @(posedge clk) begin
        if (reset) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= '0;
            wdata_axi_r <= '0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= AXI_RESP_OKAY;
            ctrl_r <= CTRL_RESET;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r <= 1'b1;
                wdata_axi_r <= s_axi_wdata;
                s_axi_wready <= 1'b0;
            end
            if (aw_got_r && w_got_r && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= AXI_RESP_OKAY;
                if (awaddr_r[11:2] == AXI_CTRL_OFS[11:2]) begin
                    ctrl_r <= wdata_axi_r[1:0];
                end else if (awaddr_r[11:2] != AXI_STATUS_OFS[11:2]
                        && awaddr_r[11:2] != AXI_CLKCFG_OFS[11:2]) begin
                    s_axi_bresp <= AXI_RESP_SLVERR;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_comb begin
        rd_word = '0;
        rd_ok = 1'b1;
        case (s_axi_araddr[11:2])
            AXI_CTRL_OFS[11:2]: rd_word[1:0] = ctrl_r;
            AXI_STATUS_OFS[11:2]: begin
                rd_word[STAT_MODE_LSB +: 2] = mode_r;
                rd_word[STAT_MUX_BIT] = mux_bus_r;
                rd_word[STAT_BUSY_BIT] = (state_r != ST_IDLE);
                rd_word[STAT_RDYEN_BIT] = strap_s.ready_enable;
            end
            AXI_CLKCFG_OFS[11:2]: begin
                rd_word[CLK_M_LSB +: DIV_M_W] = pll_div_m;
                rd_word[CLK_N_LSB +: DIV_N_W] = pll_div_n;
                rd_word[CLK_SRC_LSB +: SRC_ADDR_W] = link_source_addr;
            end
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= AXI_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_ok ? AXI_RESP_OKAY : AXI_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // wstrb ignored: the only writable register is narrow
endmodule // hip_port

// ---- src/hip_pkg.sv ----
/*
 * Constants and carriers of the host parallel port block.
 * Assumes one 125 MHz clock; pins arrive unsynchronised.
 */
package hip_pkg;

    // ========================================================
    // clock and timing
    localparam int CLK_PERIOD_PS = 8000;
    localparam int READY_HOLD_NS = 10;
    localparam int READY_HOLD_CYC = (READY_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int HOLD_CNT_W = 4;

    // ========================================================
    // host port geometry
    localparam int HOST_ADDR_W = 10;
    localparam int HOST_DATA_W = 16;
    localparam int SRC_ADDR_W = 6;
    localparam int DIV_M_W = 5;
    localparam int DIV_N_W = 6;

    // strap field positions on the data pins
    localparam int STRAP_M_LSB = 11;
    localparam int STRAP_N_LSB = 5;

    // ========================================================
    // interface selection straps
    typedef enum logic [1:0] {
        HIP_MODE_INTEL = 2'h0,
        HIP_MODE_MOTOROLA = 2'h1,
        HIP_MODE_SPI = 2'h2,
        HIP_MODE_LINK = 2'h3
    } hip_mode_e;

    // ========================================================
    // divider registers inside the host address space (byte addresses)
    localparam logic [HOST_ADDR_W-1:0] HOST_DIV_M_ADDR = 10'h0A0;
    localparam logic [HOST_ADDR_W-1:0] HOST_DIV_N_ADDR = 10'h0A2;
    localparam logic [DIV_M_W-1:0] DIV_M_RESET = 5'h00;
    localparam logic [DIV_N_W-1:0] DIV_N_RESET = 6'h00;

    // ========================================================
    // AXI4-Lite register map
    localparam logic [11:0] AXI_CTRL_OFS = 12'h000;
    localparam logic [11:0] AXI_STATUS_OFS = 12'h004;
    localparam logic [11:0] AXI_CLKCFG_OFS = 12'h008;
    localparam int CTRL_BUS16_BIT = 0;
    localparam int CTRL_BYTE_EN_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h3;
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_MUX_BIT = 2;
    localparam int STAT_BUSY_BIT = 3;
    localparam int STAT_RDYEN_BIT = 4;
    localparam int CLK_M_LSB = 0;
    localparam int CLK_N_LSB = 8;
    localparam int CLK_SRC_LSB = 16;
    localparam logic [1:0] AXI_RESP_OKAY = 2'h0;
    localparam logic [1:0] AXI_RESP_SLVERR = 2'h2;

    // ========================================================
    // carriers
    typedef struct packed {
        logic cs_n;
        logic rd_ds_n;
        logic wr_rw_n;
        logic ale;
        logic byte_sel_n;
        logic [HOST_ADDR_W-1:0] addr;
        logic [HOST_DATA_W-1:0] data;
    } hip_host_in_s;

    localparam hip_host_in_s HOST_IN_IDLE = '{ale: 1'b0, addr: '0, data: '0, default: 1'b1};

    typedef struct packed {
        logic [HOST_DATA_W-1:0] data_out;
        logic data_oe;
        logic handshake_out;
        logic handshake_oe;
    } hip_host_out_s;

    typedef struct packed {
        logic [1:0] interface_select_straps;
        logic ready_enable;
    } hip_strap_s;

    // byte lanes taking part in one access
    typedef struct packed {
        logic even_en;
        logic odd_en;
        logic even_hi;
        logic odd_hi;
    } hip_lanes_s;

endpackage

// ---- src/hip_sync.sv ----
/*
 * Two-flop synchroniser.
 * Assumes the input may change at any time.
 */
`timescale 1ns/100ps

module hip_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;

    // first stage feeds the second only
    always_ff @(posedge clk) begin
        if (reset) begin
            meta_r <= RESET_VALUE;
            q <= RESET_VALUE;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule // hip_sync

// ---- bench/hip_port_asserts.sv ----
/* checker for hip_port, bound onto every instance of it.
   assumes one clock domain and the synchronous reset of the port. */
`timescale 1ns/100ps
module hip_port_asserts
    import hip_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input hip_pkg::hip_host_in_s host_in,
    input hip_pkg::hip_strap_s straps,
    input hip_pkg::hip_host_out_s host_out,
    input hip_pkg::hip_mode_e active_mode,
    input wire logic [hip_pkg::SRC_ADDR_W-1:0] link_source_addr
);
    // ==========
    // helpers
    logic strobe_low;
    // motorola strobes on data strobe alone, r/w is only a direction
    assign strobe_low = !host_in.cs_n && (!host_in.rd_ds_n || (active_mode == HIP_MODE_INTEL && !host_in.wr_rw_n));
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // ==========
    // properties
    property p_open_drain;
        host_out.handshake_oe |-> host_out.handshake_out == 1'b0;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("handshake driven high");
    property p_cs_gate;
        host_out.handshake_oe |-> !$past(host_in.cs_n, 3);
    endproperty
    a_cs_gate: assert property (p_cs_gate) else $error("handshake without select");
    property p_rdy_gate;
        host_out.handshake_oe |-> $past(straps.ready_enable, 3);
    endproperty
    a_rdy_gate: assert property (p_rdy_gate) else $error("handshake while disabled");
    property p_release;
        !strobe_low [*8] |-> !host_out.handshake_oe;
    endproperty
    a_release: assert property (p_release) else $error("handshake not released");
    property p_after_strobe;
        $rose(host_out.handshake_oe) |-> $past(strobe_low, 2);
    endproperty
    a_after_strobe: assert property (p_after_strobe) else $error("handshake without strobe");
    property p_read_data;
        $rose(host_out.handshake_oe) && active_mode == HIP_MODE_INTEL && !host_in.rd_ds_n |-> $past(host_out.data_oe);
    endproperty
    a_read_data: assert property (p_read_data) else $error("ready before data");
    property p_serial_quiet;
        active_mode[1] |-> !host_out.handshake_oe && !host_out.data_oe;
    endproperty
    a_serial_quiet: assert property (p_serial_quiet) else $error("parallel port active in serial mode");
    property p_mode_held;
        !$past(reset) && !$past(reset, 2) |-> $stable(active_mode)
            && (active_mode == HIP_MODE_LINK || link_source_addr == '0);
    endproperty
    a_mode_held: assert property (p_mode_held) else $error("mode or source address wrong");
endmodule // hip_port_asserts

bind hip_port hip_port_asserts i_hip_port_asserts (.clk(clk), .reset(reset), .host_in(host_in),
    .straps(straps), .host_out(host_out), .active_mode(active_mode), .link_source_addr(link_source_addr));

// ---- bench/hip_host_model.sv ----
/* host controller model on the parallel port.
   assumes callers start at a clock edge. */
`timescale 1ns/100ps
module hip_host_model
    import hip_pkg::*;
(
    input wire logic clk,
    input hip_pkg::hip_host_out_s host_out,
    output hip_pkg::hip_host_in_s host_in
);
    logic ready_n;
    // board pull-up on the shared handshake line
    assign ready_n = host_out.handshake_oe ? host_out.handshake_out : 1'b1;
    initial host_in = HOST_IN_IDLE;
    // ==========
    // straps stay on the pins while reset is applied
    task automatic park(input logic [9:0] a, input logic [15:0] d);
        @(posedge clk);
        host_in <= '{ale: 1'b0, addr: a, data: d, default: 1'b1};
    endtask
    task automatic access(input logic mot, input logic wr, input logic mux, input logic [9:0] a,
                          input logic sel_n, input logic [15:0] d, output logic got, output logic [15:0] q);
        int n;
        got = 1'b0;
        q = '0;
        @(posedge clk);
        host_in.cs_n <= 1'b0;
        host_in.addr <= mux ? ~a : a;
        host_in.byte_sel_n <= sel_n;
        host_in.wr_rw_n <= mot ? !wr : 1'b1;
        host_in.ale <= mux;
        host_in.data <= mux ? {6'h00, a} : d;
        if (mux) begin
            repeat (3) @(posedge clk);
            host_in.ale <= 1'b0;
            @(posedge clk);
            host_in.data <= d;
        end
        @(posedge clk);
        if (mot || !wr) host_in.rd_ds_n <= 1'b0;
        else host_in.wr_rw_n <= 1'b0;
        for (n = 0; n < 20 && !got; n++) begin
            @(posedge clk);
            got = (ready_n === 1'b0);
            q = host_out.data_out;
        end
        host_in.rd_ds_n <= 1'b1;
        if (!mot) host_in.wr_rw_n <= 1'b1;
        // next strobe only after the device lets go of the line
        for (n = 0; n < 20 && ready_n !== 1'b1; n++) @(posedge clk);
        host_in.cs_n <= 1'b1;
        if (mot) host_in.wr_rw_n <= 1'b1;
        host_in.data <= ~d;
        repeat (2) @(posedge clk);
    endtask
endmodule // hip_host_model

// ---- bench/tb_hip_port.sv ----
/* self-checking bench for hip_port.
   assumes the checker binds itself in. */
`timescale 1ns/100ps
module tb_hip_port;
    import hip_pkg::*;
    logic clk, reset, g;
    logic [15:0] q;
    logic [31:0] rd;
    logic [1:0] rs;
    hip_strap_s straps;
    hip_host_in_s host_in;
    hip_host_out_s host_out;
    hip_mode_e active_mode;
    logic [5:0] link_source_addr, pll_div_n;
    logic [4:0] pll_div_m;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int n_mismatch = 0;
    int check_count = 0;
    hip_port i_hip_port (.*);
    hip_host_model i_host (.clk(clk), .host_out(host_out), .host_in(host_in));
    // ==========
    // shared tasks
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic give_verdict();
        if (n_mismatch == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic axi_rd(input logic [11:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
        logic seen;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            seen = (s_axi_bvalid === 1'b1);
        end while (!seen);
        s_axi_bready <= 1'b0;
    endtask
    task automatic do_reset(input hip_mode_e m, input logic [9:0] a, input logic [15:0] d);
        reset <= 1'b1;
        straps <= '{interface_select_straps: m, ready_enable: 1'b1};
        i_host.park(a, d);
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        chk("active_mode", m, active_mode);
    endtask
    // ==========
    // scenarios
    task automatic t_intel();
        do_reset(HIP_MODE_INTEL, 10'h000, 16'h0000);
        i_host.access(0, 1, 0, HOST_DIV_M_ADDR, 0, 16'h3311, g, q);
        chk("write ready", 1, g);
        chk("word m", 5'h11, pll_div_m);
        i_host.access(0, 1, 0, HOST_DIV_N_ADDR, 1, 16'hFF2C, g, q);
        chk("even byte n", 6'h2C, pll_div_n);
        i_host.access(0, 1, 0, HOST_DIV_M_ADDR | 10'h001, 0, 16'h5A1F, g, q);
        chk("odd byte m", 5'h11, pll_div_m);
        i_host.access(0, 1, 0, HOST_DIV_M_ADDR | 10'h001, 1, 16'h0505, g, q);
        chk("no transfer ready", 1, g);
        i_host.access(0, 0, 0, HOST_DIV_M_ADDR, 0, 16'h0000, g, q);
        chk("word read", 16'h5A11, q);
        straps.ready_enable <= 1'b0;
        i_host.access(0, 1, 0, HOST_DIV_M_ADDR, 0, 16'h3311, g, q);
        chk("ready disabled", 0, g);
        repeat (8) @(posedge clk);
        straps.ready_enable <= 1'b1;
    endtask
    task automatic t_axi();
        axi_rd(AXI_CTRL_OFS);
        chk("ctrl reset", 32'h3, rd);
        axi_rd(AXI_STATUS_OFS);
        chk("status", 32'h10, rd & 32'h1F);
        axi_rd(12'h010);
        chk("unmapped resp", AXI_RESP_SLVERR, rs);
        axi_wr(AXI_CTRL_OFS, 32'h1);
        i_host.access(0, 1, 0, HOST_DIV_N_ADDR, 1, 16'h0007, g, q);
        chk("byte refused", 6'h2C, pll_div_n);
        axi_wr(AXI_CTRL_OFS, 32'h2);
        i_host.access(0, 1, 0, HOST_DIV_M_ADDR, 0, 16'hFF09, g, q);
        chk("bus8 m", 5'h09, pll_div_m);
        axi_wr(AXI_CTRL_OFS, 32'h3);
        i_host.access(0, 1, 1, HOST_DIV_N_ADDR, 0, 16'h0031, g, q);
        chk("mux n", 6'h31, pll_div_n);
        axi_rd(AXI_STATUS_OFS);
        chk("mux seen", 1, rd[STAT_MUX_BIT]);
    endtask
    task automatic t_moto();
        do_reset(HIP_MODE_MOTOROLA, 10'h000, 16'h0000);
        i_host.access(1, 1, 0, HOST_DIV_M_ADDR, 1, 16'h0E77, g, q);
        chk("moto even byte", 5'h0E, pll_div_m);
        chk("moto ack", 1, g);
        i_host.access(1, 1, 0, HOST_DIV_N_ADDR, 0, 16'h1500, g, q);
        chk("moto word n", 6'h15, pll_div_n);
        i_host.access(1, 0, 0, HOST_DIV_N_ADDR, 0, 16'h0000, g, q);
        chk("moto word read", 16'h1500, q);
    endtask
    task automatic t_serial();
        do_reset(HIP_MODE_LINK, 10'h02B, 16'h9D40);
        chk("link source", 6'h2B, link_source_addr);
        chk("strap m", 5'h13, pll_div_m);
        chk("strap n", 6'h2A, pll_div_n);
        i_host.access(0, 1, 0, HOST_DIV_M_ADDR, 0, 16'h0001, g, q);
        chk("parallel off", 0, g);
        chk("m kept", 5'h13, pll_div_m);
        do_reset(HIP_MODE_SPI, 10'h015, 16'h52BF);
        chk("spi source", 0, link_source_addr);
        chk("spi m", 5'h0A, pll_div_m);
        axi_rd(AXI_CLKCFG_OFS);
        chk("clkcfg", 32'h0000150A, rd);
    endtask
    // ==========
    // clock, watchdog, sequence
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        give_verdict();
    end
    initial begin
        reset = 1'b1;
        straps = '{interface_select_straps: HIP_MODE_INTEL, ready_enable: 1'b1};
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        repeat (2) @(posedge clk);
        t_intel();
        t_axi();
        t_moto();
        t_serial();
        give_verdict();
    end
endmodule // tb_hip_port
